/* File: shared/fsr_pkg.sv */
package fsr_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_SUSPEND_MODE = 32'h007fe0e0;
	localparam logic [31:0] ADDR_CLOCK_NOTIFY = 32'h007fe0e4;
	localparam logic [31:0] ADDR_WINDOW_MONITOR = 32'h007fe0f0;
	// access-window monitor layout
	localparam int WIN_START_LSB = 0;
	localparam int WIN_START_MSB = 11;
	localparam int PROTECT_BIT = 15;
	localparam int WIN_END_LSB = 16;
	localparam int WIN_END_MSB = 27;
	localparam int SWAP_BIT = 31;
	localparam logic [31:0] MONITOR_MASK = 32'h8fff8fff;
	localparam logic [31:0] MONITOR_BLANK = 32'hffffffff;
	// erase-suspend mode layout
	localparam int SUSP_BIT = 0;
	localparam logic SUSPEND_MODE_RESET = 1'h0;
	// clock notify layout
	localparam int MHZ_LSB = 0;
	localparam int MHZ_MSB = 7;
	localparam int KEY_LSB = 8;
	localparam int KEY_MSB = 15;
	localparam logic [7:0] CLOCK_KEY = 8'h1e;
	localparam logic [7:0] CLOCK_MHZ_RESET = 8'h3c;
	// a half-word write is the two low byte lanes only
	localparam logic [3:0] BE_HALF = 4'h3;
	// startup area select field
	localparam int SAS_FORCE_BIT = 1;
	localparam int SAS_AREA_BIT = 0;
	localparam logic [31:0] READ_ZERO = 32'h00000000;
	localparam logic [7:0] MHZ_ONE = 8'h01;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	typedef enum logic [0:0]
	{
		LOAD_IDLE = 1'b0,
		LOAD_AFTER_RESET = 1'b1
	} fsr_load_t;
endpackage

/* File: verilog/fsr_key_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module fsr_key_gate #(
	parameter logic [7:0] KEY = 8'h00
) (
	// write request
	input wire logic i_hit,
	input wire logic [3:0] i_be,
	input wire logic [7:0] i_key,
	input wire logic i_ready,
	// verdict
	output logic o_accept
);
	// key byte and value must arrive in one half-word write
	always_comb
	begin
		o_accept = i_hit && (i_be == fsr_pkg::BE_HALF) && (i_key == KEY) && i_ready;
	end
endmodule // fsr_key_gate
`default_nettype wire

/* File: verilog/fsr_us_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module fsr_us_tick (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// notified frequency
	input wire logic [7:0] i_mhz,
	// one pulse per notified microsecond
	output logic o_tick
);
	logic [7:0] count;
	logic [7:0] limit;
	always_comb
	begin
		// zero would stall the timebase; treat it as one
		limit = (i_mhz == fsr_pkg::COUNT_ZERO) ? fsr_pkg::COUNT_ZERO : i_mhz - fsr_pkg::MHZ_ONE;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			count <= fsr_pkg::COUNT_ZERO;
			o_tick <= 1'b0;
		end
		else if (count >= limit)
		begin
			count <= fsr_pkg::COUNT_ZERO;
			o_tick <= 1'b1;
		end
		else
		begin
			count <= count + fsr_pkg::MHZ_ONE;
			o_tick <= 1'b0;
		end
	end
	AST_TICK_GAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_tick && i_mhz >= 8'h02 && $stable(i_mhz)) |=> !o_tick)
		else $error("processing tick repeated too soon");
endmodule // fsr_us_tick
`default_nettype wire

/* File: verilog/fsr_config_regs.sv */
// Functional notes
// - window monitor: read-only word, start 11:0, protect 15, end 27:16, swap 31
// - reserved bit groups read as zero except in the all-ones blank value; software writes zero there
// - monitor reloads from option memory at reset and on configuration command
// - never-configured option memory shows all ones in the monitor
// - protect flag reports protected or unprotected window settings
// - protect flag gates window setting, configuration clear and startup control writes; here it only drives o_window_change_enable
// - window end holds the first block address past the window
// - swap flag exchanges startup area 0 and 1 address ranges
// - startup select 1x overrides the swap flag
// - suspend mode bit picks suspension or erasure priority on suspend
// - suspend mode resets on reset and on setup initialisation
// - clock frequency writes are taken only while the sequencer is ready
// - clock frequency updates only by one half-word write carrying the key
// - key byte is not stored and reads as zero
// - clock frequency resets to the highest permitted frequency
// - processing times derive from the notified frequency
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fsr_config_regs (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_be,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// option-setting memory
	input wire logic [31:0] i_option_word,
	input wire logic i_option_blank,
	input wire logic i_config_cmd_done,
	// sequencer side
	input wire logic i_sequencer_ready_flag,
	input wire logic i_setup_init_bit,
	input wire logic [1:0] i_startup_area_select,
	// decoded settings
	output logic [11:0] o_window_start,
	output logic [11:0] o_window_end,
	output logic o_window_protect_flag,
	output logic o_window_change_enable,
	output logic o_startup_areas_swapped,
	output logic o_suspend_priority_select,
	output logic [7:0] o_clock_mhz_value,
	output logic o_processing_tick
);
	logic [31:0] access_window_monitor;
	logic suspend_priority_select;
	logic [7:0] clock_mhz_value;
	fsr_pkg::fsr_load_t load_state;
	logic hit_suspend;
	logic hit_clock;
	logic hit_monitor;
	logic clock_accept;
	logic load_now;
	logic [31:0] next_monitor;
	logic next_swapped;
	logic [31:0] next_rdata;

	always_comb
	begin
		hit_suspend = (i_addr == fsr_pkg::ADDR_SUSPEND_MODE);
		hit_clock = (i_addr == fsr_pkg::ADDR_CLOCK_NOTIFY);
		hit_monitor = (i_addr == fsr_pkg::ADDR_WINDOW_MONITOR);
	end

	fsr_key_gate #(
		.KEY(fsr_pkg::CLOCK_KEY)
	) u_clock_key (
		.i_hit(i_wr && hit_clock),
		.i_be(i_be),
		.i_key(i_wdata[fsr_pkg::KEY_MSB:fsr_pkg::KEY_LSB]),
		.i_ready(i_sequencer_ready_flag),
		.o_accept(clock_accept)
	);

	// option memory load: the reset value is constant, the real copy follows the release
	always_comb
	begin
		load_now = (load_state == fsr_pkg::LOAD_AFTER_RESET) || i_config_cmd_done;
		if (i_option_blank)
		begin
			next_monitor = fsr_pkg::MONITOR_BLANK;
		end
		else
		begin
			next_monitor = i_option_word & fsr_pkg::MONITOR_MASK;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			load_state <= fsr_pkg::LOAD_AFTER_RESET;
		end
		else
		begin
			case (load_state)
				fsr_pkg::LOAD_AFTER_RESET: load_state <= fsr_pkg::LOAD_IDLE;
				fsr_pkg::LOAD_IDLE: load_state <= fsr_pkg::LOAD_IDLE;
				default: load_state <= fsr_pkg::LOAD_IDLE;
			endcase
		end
	end

	// software writes to the monitor are dropped; only the loader changes it
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			access_window_monitor <= fsr_pkg::MONITOR_BLANK;
		end
		else if (load_now)
		begin
			access_window_monitor <= next_monitor;
		end
	end

	// decoded window settings; end is one block past the window as loaded
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_window_start <= fsr_pkg::MONITOR_BLANK[fsr_pkg::WIN_START_MSB:fsr_pkg::WIN_START_LSB];
			o_window_end <= fsr_pkg::MONITOR_BLANK[fsr_pkg::WIN_END_MSB:fsr_pkg::WIN_END_LSB];
			o_window_protect_flag <= 1'b1;
			o_window_change_enable <= 1'b0;
		end
		else
		begin
			o_window_start <= access_window_monitor[fsr_pkg::WIN_START_MSB:fsr_pkg::WIN_START_LSB];
			o_window_end <= access_window_monitor[fsr_pkg::WIN_END_MSB:fsr_pkg::WIN_END_LSB];
			o_window_protect_flag <= access_window_monitor[fsr_pkg::PROTECT_BIT];
			// held off until the first load, so nothing slips through before the copy
			o_window_change_enable <= access_window_monitor[fsr_pkg::PROTECT_BIT]
				&& (load_state == fsr_pkg::LOAD_IDLE);
		end
	end

	// startup area mapping
	always_comb
	begin
		if (i_startup_area_select[fsr_pkg::SAS_FORCE_BIT])
		begin
			next_swapped = !i_startup_area_select[fsr_pkg::SAS_AREA_BIT];
		end
		else
		begin
			next_swapped = access_window_monitor[fsr_pkg::SWAP_BIT];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_startup_areas_swapped <= 1'b0;
		end
		else
		begin
			o_startup_areas_swapped <= next_swapped;
		end
	end

	// erase-suspend mode
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			suspend_priority_select <= fsr_pkg::SUSPEND_MODE_RESET;
		end
		else if (i_setup_init_bit)
		begin
			suspend_priority_select <= fsr_pkg::SUSPEND_MODE_RESET;
		end
		else if (i_wr && hit_suspend && i_be[0])
		begin
			suspend_priority_select <= i_wdata[fsr_pkg::SUSP_BIT];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_suspend_priority_select <= fsr_pkg::SUSPEND_MODE_RESET;
		end
		else
		begin
			o_suspend_priority_select <= suspend_priority_select;
		end
	end

	// clock frequency notify; key is checked but never kept
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			clock_mhz_value <= fsr_pkg::CLOCK_MHZ_RESET;
		end
		else if (clock_accept)
		begin
			clock_mhz_value <= i_wdata[fsr_pkg::MHZ_MSB:fsr_pkg::MHZ_LSB];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_clock_mhz_value <= fsr_pkg::CLOCK_MHZ_RESET;
		end
		else
		begin
			o_clock_mhz_value <= clock_mhz_value;
		end
	end

	// a high notified figure only stretches the timebase, which is the safe direction
	fsr_us_tick u_tick (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_mhz(clock_mhz_value),
		.o_tick(o_processing_tick)
	);

	// read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = fsr_pkg::READ_ZERO;
		if (hit_monitor)
		begin
			next_rdata = access_window_monitor;
		end
		else if (hit_suspend)
		begin
			next_rdata[fsr_pkg::SUSP_BIT] = suspend_priority_select;
		end
		else if (hit_clock)
		begin
			next_rdata[fsr_pkg::MHZ_MSB:fsr_pkg::MHZ_LSB] = clock_mhz_value;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_rdata <= fsr_pkg::READ_ZERO;
		end
		else if (i_rd)
		begin
			o_rdata <= next_rdata;
		end
		else
		begin
			o_rdata <= fsr_pkg::READ_ZERO;
		end
	end

	AST_KEY_ACCEPT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr && hit_clock && i_be == 4'h3 && i_wdata[15:8] == 8'h1e && i_sequencer_ready_flag)
		|=> (clock_mhz_value == $past(i_wdata[7:0])) ##1 (o_clock_mhz_value == $past(i_wdata[7:0], 2)))
		else $error("keyed clock write not stored");

	AST_NOT_READY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr && hit_clock && !i_sequencer_ready_flag) |=> $stable(clock_mhz_value))
		else $error("clock write taken while sequencer busy");

	AST_BAD_KEY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_wr && (i_wdata[15:8] != 8'h1e || i_be != 4'h3)) |=> $stable(clock_mhz_value))
		else $error("clock value changed without valid key");

	AST_KEY_READS_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && hit_clock) |=> (o_rdata[31:8] == 24'h000000 && o_rdata[7:0] == clock_mhz_value))
		else $error("clock register read wrong");

	AST_RESERVED_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd && hit_monitor && access_window_monitor != 32'hffffffff)
		|=> (o_rdata[14:12] == 3'h0 && o_rdata[30:28] == 3'h0))
		else $error("reserved monitor bits not zero");

	AST_CONFIG_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_config_cmd_done && !i_option_blank)
		|=> (access_window_monitor == ($past(i_option_word) & 32'h8fff8fff)))
		else $error("monitor not loaded from option memory");

	AST_BLANK_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(load_now && i_option_blank) |=> (access_window_monitor == 32'hffffffff))
		else $error("blank option memory not shown as all ones");

	AST_SETUP_INIT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_setup_init_bit |=> (suspend_priority_select == 1'b0) ##1 (o_suspend_priority_select == 1'b0))
		else $error("suspend mode not initialised");

	AST_SWAP_MAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_startup_area_select[1]) |=> (o_startup_areas_swapped == !$past(i_startup_area_select[0])))
		else $error("forced startup select not applied");

	AST_RESET_MHZ: assert property (@(posedge i_clk)
		!i_reset_n |=> (clock_mhz_value == 8'h3c))
		else $error("clock frequency reset value wrong");

	AST_PROTECT_GATE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_window_change_enable |-> o_window_protect_flag)
		else $error("change enabled while window protected");
endmodule // fsr_config_regs
`default_nettype wire

/* File: verif/tb_fsr_config_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fsr_config_regs;
	logic i_clk;
	logic i_reset_n;
	logic [31:0] i_addr;
	logic [31:0] i_wdata;
	logic [3:0] i_be;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic [31:0] i_option_word;
	logic i_option_blank;
	logic i_config_cmd_done;
	logic i_sequencer_ready_flag;
	logic i_setup_init_bit;
	logic [1:0] i_startup_area_select;
	logic [11:0] o_window_start;
	logic [11:0] o_window_end;
	logic o_window_protect_flag;
	logic o_window_change_enable;
	logic o_startup_areas_swapped;
	logic o_suspend_priority_select;
	logic [7:0] o_clock_mhz_value;
	logic o_processing_tick;
	int fail_count;
	int n_checks;
	int k;
	int j;
	int gap;
	logic [15:0] lfsr;
	logic [31:0] rdv;
	logic [31:0] word;
	logic [31:0] mon;
	logic [7:0] mhz;

	fsr_config_regs DUT (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_option_word(i_option_word),
		.i_option_blank(i_option_blank), .i_config_cmd_done(i_config_cmd_done),
		.i_sequencer_ready_flag(i_sequencer_ready_flag), .i_setup_init_bit(i_setup_init_bit),
		.i_startup_area_select(i_startup_area_select), .o_window_start(o_window_start),
		.o_window_end(o_window_end), .o_window_protect_flag(o_window_protect_flag),
		.o_window_change_enable(o_window_change_enable), .o_startup_areas_swapped(o_startup_areas_swapped),
		.o_suspend_priority_select(o_suspend_priority_select), .o_clock_mhz_value(o_clock_mhz_value),
		.o_processing_tick(o_processing_tick)
	);

	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	// blank option memory shows all ones, reserved groups are cleared otherwise
	function automatic logic [31:0] exp_monitor(input logic [31:0] w, input logic blank);
		return blank ? 32'hffffffff : (w & 32'h8fff8fff);
	endfunction

	function automatic logic exp_swap(input logic [1:0] sas, input logic flag);
		return sas[1] ? ~sas[0] : flag;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_be <= be;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample mid-cycle there
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	// bounded wait: the first gap after a change may be partial, so measure the next one
	task automatic tick_gap(output int g);
		int n;
		n = 0;
		while (o_processing_tick !== 1'b1 && n < 300)
		begin
			@(negedge i_clk);
			n++;
		end
		g = 0;
		do
		begin
			@(negedge i_clk);
			g++;
		end while (o_processing_tick !== 1'b1 && g < 300);
		if (n >= 300 || g >= 300)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: processing tick missing", $time);
			complete_run();
		end
	endtask

	initial
	begin
		lfsr = 16'h0047;
		fail_count = 0;
		n_checks = 0;
		i_reset_n = 1'b0;
		i_addr = 32'h00000000;
		i_wdata = 32'h00000000;
		i_be = 4'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_option_word = 32'h00000000;
		i_option_blank = 1'b1;
		i_config_cmd_done = 1'b0;
		i_sequencer_ready_flag = 1'b1;
		i_setup_init_bit = 1'b0;
		i_startup_area_select = 2'h0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		idle(3);
		rd(fsr_pkg::ADDR_WINDOW_MONITOR, rdv);
		chk(rdv, 32'hffffffff, "monitor after reset");
		rd(fsr_pkg::ADDR_CLOCK_NOTIFY, rdv);
		chk(rdv, {24'h000000, fsr_pkg::CLOCK_MHZ_RESET}, "clock after reset");
		rd(fsr_pkg::ADDR_SUSPEND_MODE, rdv);
		chk(rdv, 32'h00000000, "suspend after reset");
		rd(32'h007fe0ec, rdv);
		chk(rdv, 32'h00000000, "unmapped read");
		$display("test reset values done");
		wr(fsr_pkg::ADDR_CLOCK_NOTIFY, {16'h0000, fsr_pkg::CLOCK_KEY, 8'h14}, fsr_pkg::BE_HALF);
		for (k = 0; k < 4; k++)
		begin
			word = {rnd(), rnd()};
			mon = exp_monitor(word, k == 3);
			@(posedge i_clk);
			i_option_word <= word;
			i_option_blank <= (k == 3);
			i_config_cmd_done <= 1'b1;
			@(posedge i_clk);
			i_config_cmd_done <= 1'b0;
			i_option_word <= ~word;
			idle(2);
			chk(o_window_start, mon[11:0], "window start");
			chk(o_window_end, mon[27:16], "window end");
			chk(o_window_protect_flag, mon[15], "protect flag");
			chk(o_window_change_enable, mon[15], "change enable");
			wr(fsr_pkg::ADDR_WINDOW_MONITOR, ~word, 4'hf);
			rd(fsr_pkg::ADDR_WINDOW_MONITOR, rdv);
			chk(rdv, mon, "monitor after load");
			for (j = 0; j < 4; j++)
			begin
				@(posedge i_clk);
				i_startup_area_select <= j[1:0];
				idle(2);
				chk(o_startup_areas_swapped, exp_swap(j[1:0], mon[31]), "startup swap");
			end
		end
		$display("test window loads done");
		wr(fsr_pkg::ADDR_SUSPEND_MODE, 32'h0000ffff, 4'h3);
		rd(fsr_pkg::ADDR_SUSPEND_MODE, rdv);
		chk(rdv, 32'h00000001, "suspend readback");
		chk(o_suspend_priority_select, 1'b1, "suspend output");
		@(posedge i_clk);
		i_setup_init_bit <= 1'b1;
		@(posedge i_clk);
		i_setup_init_bit <= 1'b0;
		rd(fsr_pkg::ADDR_SUSPEND_MODE, rdv);
		chk(rdv, 32'h00000000, "suspend after setup init");
		$display("test suspend mode done");
		for (k = 0; k < 4; k++)
		begin
			word = {16'h0000, rnd()};
			// never below the true 20 MHz clock; whole MHz only
			mhz = (k == 0) ? 8'h14 : (k == 1) ? 8'hff : (k == 2) ? 8'h15 : {1'b0, word[6:0]} + 8'h14;
			wr(fsr_pkg::ADDR_CLOCK_NOTIFY, {16'h0000, fsr_pkg::CLOCK_KEY, mhz}, fsr_pkg::BE_HALF);
			rd(fsr_pkg::ADDR_CLOCK_NOTIFY, rdv);
			chk(rdv, {24'h000000, mhz}, "clock readback");
			chk(o_clock_mhz_value, mhz, "clock output");
			tick_gap(gap);
			tick_gap(gap);
			chk(32'(gap), {24'h000000, mhz}, "tick spacing");
			wr(fsr_pkg::ADDR_CLOCK_NOTIFY, {16'h0000, 8'h1f, ~mhz}, fsr_pkg::BE_HALF);
			wr(fsr_pkg::ADDR_CLOCK_NOTIFY, {16'h0000, fsr_pkg::CLOCK_KEY, ~mhz}, 4'hf);
			rd(fsr_pkg::ADDR_CLOCK_NOTIFY, rdv);
			chk(rdv, {24'h000000, mhz}, "bad key or width");
			@(posedge i_clk);
			i_sequencer_ready_flag <= 1'b0;
			wr(fsr_pkg::ADDR_CLOCK_NOTIFY, {16'h0000, fsr_pkg::CLOCK_KEY, ~mhz}, fsr_pkg::BE_HALF);
			i_sequencer_ready_flag <= 1'b1;
			idle(2);
			chk(o_clock_mhz_value, mhz, "write while busy");
		end
		$display("test clock notify done");
		// second reset: the loader must copy a configured option word, not only the blank one
		word = {rnd(), rnd()};
		mon = exp_monitor(word, 1'b0);
		wr(fsr_pkg::ADDR_SUSPEND_MODE, 32'h00000001, 4'h1);
		@(posedge i_clk);
		i_option_word <= word;
		i_option_blank <= 1'b0;
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		idle(3);
		rd(fsr_pkg::ADDR_WINDOW_MONITOR, rdv);
		chk(rdv, mon, "monitor after reset load");
		chk(o_window_end, mon[27:16], "window end after reset");
		chk(o_window_change_enable, mon[15], "change enable after reset");
		rd(fsr_pkg::ADDR_CLOCK_NOTIFY, rdv);
		chk(rdv, {24'h000000, fsr_pkg::CLOCK_MHZ_RESET}, "clock after second reset");
		rd(fsr_pkg::ADDR_SUSPEND_MODE, rdv);
		chk(rdv, 32'h00000000, "suspend after second reset");
		$display("test second reset done");
		complete_run();
	end
endmodule // tb_fsr_config_regs
`default_nettype wire
